// [hw/ucbg_pkg.sv]
// Constants, layouts and helpers for the serial control block
package ucbg_pkg;

  ////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_FLAGS  = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_BAUD   = 8'h08;
  localparam logic [7:0] OFF_CTL    = 8'h0c;
  localparam logic [7:0] OFF_RX_EXT = 8'h10;
  localparam logic [7:0] OFF_TX_EXT = 8'h14;

  ////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] BAUD_RESET     = 8'h00;
  localparam logic [7:0] EXT_RESET      = 8'h00;
  localparam logic [7:0] HOLD_RESET     = 8'h00;
  localparam logic       TX_EMPTY_RESET = 1'b1;
  localparam logic       TX_DONE_RESET  = 1'b1;

  ////////////////////////////////////////
  // Flag register bit positions
  localparam int FLAG_TX_EMPTY_BIT = 7;
  localparam int FLAG_TX_DONE_BIT  = 6;
  localparam int FLAG_RX_FULL_BIT  = 5;
  localparam int FLAG_IDLE_BIT     = 4;
  localparam int FLAG_OVFL_BIT     = 3;

  ////////////////////////////////////////
  // Rate and frame figures
  localparam logic [3:0] OVERSAMPLE_SHIFT = 4'h4;
  localparam logic [3:0] PRESCALE_0       = 4'h1;
  localparam logic [3:0] PRESCALE_1       = 4'h3;
  localparam logic [3:0] PRESCALE_2       = 4'h4;
  localparam logic [3:0] PRESCALE_3       = 4'hd;
  localparam logic [3:0] DATA_BITS        = 4'h8;
  localparam logic [3:0] FRAME_LAST       = 4'h9;
  localparam logic [3:0] IDLE_BITS        = 4'ha;
  localparam logic [7:0] EXT_OFF          = 8'h00;

  ////////////////////////////////////////
  // Register layouts and enumerations
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic line_quiet_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_mute;
    logic tx_brk_send;
  } ucbg_ctl_type;

  typedef struct packed {
    logic [1:0] base_div_sel;
    logic [2:0] tx_baud_div;
    logic [2:0] rx_baud_div;
  } ucbg_baud_type;

  typedef enum logic [1:0] {
    KIND_DATA     = 2'b00,
    KIND_BREAK    = 2'b01,
    KIND_PREAMBLE = 2'b10
  } ucbg_kind_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ucbg_rx_state_type;

  ////////////////////////////////////////
  // Clock cycles per bit for either path
  function automatic logic [15:0] ucbg_divisor(input logic [1:0] sel,
                                                input logic [2:0] code,
                                                input logic [7:0] ext);
    logic [15:0] base;
    case (sel)
      2'b00:   base = {12'h000, PRESCALE_0};
      2'b01:   base = {12'h000, PRESCALE_1};
      2'b10:   base = {12'h000, PRESCALE_2};
      default: base = {12'h000, PRESCALE_3};
    endcase
    if (ext != EXT_OFF) begin
      ucbg_divisor = {8'h00, ext} << OVERSAMPLE_SHIFT;
    end else begin
      ucbg_divisor = (base << code) << OVERSAMPLE_SHIFT;
    end
  endfunction : ucbg_divisor

endpackage : ucbg_pkg

// [hw/ucbg_rate_gen.sv]
// Bit-rate tick generator with restartable phase
module ucbg_rate_gen #(
  parameter int DIV_W     = 16,
  parameter bit MID_START = 1'b0
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Control
  input  wire logic [DIV_W-1:0] divisor_in,
  input  wire logic             restart_in,
  // Tick
  output logic                  tick_out
);

  initial begin
    if (DIV_W < 16) $error("DIV_W too small");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } ucbg_rg_state_type;

  ucbg_rg_state_type st_r, st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (restart_in) begin
      // First tick half a bit after restart with MID_START, a full bit after it without
      st_nxt.cnt = MID_START ? (divisor_in >> 1) : '0;
    end else if (st_r.cnt >= divisor_in - 1'b1) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

endmodule : ucbg_rate_gen

// [hw/ucbg_top.sv]
// Serial transceiver control, data buffers and baud generation behind APB
//
// Functional notes
// - tx_empty_irq_en routes tx_buf_empty to irq.
// - tx_done_irq_en routes tx_done to irq.
// - rx_full_irq_en routes overrun or rx_buf_full to irq.
// - line_quiet_irq_en routes the idle flag to irq.
// - tx_on off then on mid-frame queues a preamble.
// - First frame waits two bit times after tx_on rises (tx_wait holds off the first tick).
// - Pin released unless tx_on was ever set and an enable holds.
// - rx_on starts start-bit search; clearing stops it.
// - rx_mute mutes the receiver; a detected wake-up clears it.
// - While tx_brk_send is set, break words are sent.
// - Clearing tx_brk_send queues one more break after the current word.
// - Data address writes tx_hold_buf and reads rx_hold_buf.
// - base_div_sel picks a first prescale of 1, 3, 4 or 13.
// - tx_baud_div picks a transmit divisor of two to the code.
// - rx_baud_div picks a receive divisor of two to the code.
// - Nonzero rx_ext_div divides the by-16 stage for the receiver.
// - Nonzero tx_ext_div divides the by-16 stage for the transmitter.
// - Both extended prescalers reset to zero, leaving conventional rates.
// - tx_buf_empty sets on load to shifter; flags read plus data write clear.
// - rx_buf_full sets on word arrival; flags read plus data read clear.
module ucbg_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Serial line
  input  wire logic              rxd_in,
  output logic                   txd_out,
  output logic                   txd_oe_out,
  // Interrupt
  output logic                   irq_out
);

  initial begin
    if (ADDR_W < 5) $error("ADDR_W too small");
  end

  ////////////////////////////////////////
  // State
  typedef struct packed {
    ucbg_pkg::ucbg_ctl_type      ctl;
    ucbg_pkg::ucbg_baud_type     baud;
    logic [7:0]                  rx_ext_div;
    logic [7:0]                  tx_ext_div;
    logic [7:0]                  tx_hold_buf;
    logic [7:0]                  rx_hold_buf;
    logic                        tx_buf_empty;
    logic                        tx_done;
    logic                        rx_buf_full;
    logic                        idle;
    logic                        rx_ovfl;
    logic                        flags_seen;
    logic                        tx_ever;
    logic                        tx_wait;
    logic                        pre_pend;
    logic                        brk_pend;
    logic                        tx_off_busy;
    ucbg_pkg::ucbg_rx_state_type rx_state;
    logic [7:0]                  rx_shift;
    logic [3:0]                  rx_cnt;
    logic [3:0]                  quiet_cnt;
    logic                        quiet_armed;
    logic                        rx_prev;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic                        txd;
    logic                        txd_oe;
    logic                        irq;
  } ucbg_state_type;

  ucbg_state_type st_r, st_nxt;

  logic [15:0]             tx_divisor;
  logic [15:0]             rx_divisor;
  logic                    tx_tick;
  logic                    rx_tick;
  logic                    tx_restart;
  logic                    rx_restart;
  logic                    tx_start;
  ucbg_pkg::ucbg_kind_type tx_kind;
  logic                    tx_line;
  logic                    tx_busy;
  logic                    tx_taken;
  logic                    tx_frame_done;

  ////////////////////////////////////////
  // Rate generation
  always_comb begin
    tx_divisor = ucbg_pkg::ucbg_divisor(st_r.baud.base_div_sel, st_r.baud.tx_baud_div,
                                        st_r.tx_ext_div);
    rx_divisor = ucbg_pkg::ucbg_divisor(st_r.baud.base_div_sel, st_r.baud.rx_baud_div,
                                        st_r.rx_ext_div);
  end

  // Realign bit clock on enable so the first frame waits two bit times
  assign tx_restart = st_nxt.ctl.tx_on & ~st_r.ctl.tx_on;
  assign rx_restart = (st_r.rx_state == ucbg_pkg::RX_IDLE) & st_r.ctl.rx_on
                      & st_r.rx_prev & ~rxd_in;

  ucbg_rate_gen #(
    .DIV_W     (16),
    .MID_START (1'b0)
  ) u_tx_rate (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .divisor_in (tx_divisor),
    .restart_in (tx_restart),
    .tick_out   (tx_tick)
  );

  ucbg_rate_gen #(
    .DIV_W     (16),
    .MID_START (1'b1)
  ) u_rx_rate (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .divisor_in (rx_divisor),
    .restart_in (rx_restart),
    .tick_out   (rx_tick)
  );

  ////////////////////////////////////////
  // Request priority: break, preamble, data
  always_comb begin
    tx_kind  = ucbg_pkg::KIND_DATA;
    tx_start = 1'b0;
    if (st_r.ctl.tx_on && !st_r.tx_wait) begin
      if (st_r.ctl.tx_brk_send || st_r.brk_pend) begin
        tx_kind  = ucbg_pkg::KIND_BREAK;
        tx_start = 1'b1;
      end else if (st_r.pre_pend) begin
        tx_kind  = ucbg_pkg::KIND_PREAMBLE;
        tx_start = 1'b1;
      end else if (!st_r.tx_buf_empty) begin
        tx_start = 1'b1;
      end
    end
  end

  ucbg_tx_shift u_tx_shift (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .tick_in    (tx_tick),
    .start_in   (tx_start),
    .kind_in    (tx_kind),
    .data_in    (st_r.tx_hold_buf),
    .line_out   (tx_line),
    .busy_out   (tx_busy),
    .taken_out  (tx_taken),
    .done_out   (tx_frame_done)
  );

  ////////////////////////////////////////
  // Next state
  always_comb begin
    logic             acc;
    logic             hit;
    logic             wr_data;
    logic             rd_data;
    logic [7:0]       rdv;
    logic [7:0]       wv;
    logic [ADDR_W-1:0] a;
    acc     = psel_in & penable_in & st_r.pready;
    a       = paddr_in;
    wv      = pwdata_in[7:0];
    hit     = 1'b1;
    wr_data = 1'b0;
    rd_data = 1'b0;
    rdv     = 8'h00;
    st_nxt  = st_r;

    // Register decode
    case (a)
      ADDR_W'(ucbg_pkg::OFF_FLAGS): begin
        rdv[ucbg_pkg::FLAG_TX_EMPTY_BIT] = st_r.tx_buf_empty;
        rdv[ucbg_pkg::FLAG_TX_DONE_BIT]  = st_r.tx_done;
        rdv[ucbg_pkg::FLAG_RX_FULL_BIT]  = st_r.rx_buf_full;
        rdv[ucbg_pkg::FLAG_IDLE_BIT]     = st_r.idle;
        rdv[ucbg_pkg::FLAG_OVFL_BIT]     = st_r.rx_ovfl;
      end
      ADDR_W'(ucbg_pkg::OFF_DATA):   rdv = st_r.rx_hold_buf;
      ADDR_W'(ucbg_pkg::OFF_BAUD):   rdv = st_r.baud;
      ADDR_W'(ucbg_pkg::OFF_CTL):    rdv = st_r.ctl;
      ADDR_W'(ucbg_pkg::OFF_RX_EXT): rdv = st_r.rx_ext_div;
      ADDR_W'(ucbg_pkg::OFF_TX_EXT): rdv = st_r.tx_ext_div;
      default:                       hit = 1'b0;
    endcase

    // APB: one wait state, data and error registered
    st_nxt.pready  = psel_in & penable_in & ~st_r.pready;
    st_nxt.prdata  = {24'h000000, rdv};
    st_nxt.pslverr = psel_in & penable_in & ~st_r.pready & ~hit;

    if (acc && hit) begin
      if (pwrite_in) begin
        case (a)
          ADDR_W'(ucbg_pkg::OFF_DATA): begin
            st_nxt.tx_hold_buf = wv;
            wr_data            = 1'b1;
          end
          ADDR_W'(ucbg_pkg::OFF_BAUD):   st_nxt.baud       = wv;
          ADDR_W'(ucbg_pkg::OFF_CTL):    st_nxt.ctl        = wv;
          ADDR_W'(ucbg_pkg::OFF_RX_EXT): st_nxt.rx_ext_div = wv;
          ADDR_W'(ucbg_pkg::OFF_TX_EXT): st_nxt.tx_ext_div = wv;
          default: ;
        endcase
      end else begin
        rd_data = (a == ADDR_W'(ucbg_pkg::OFF_DATA));
      end
      if (a == ADDR_W'(ucbg_pkg::OFF_FLAGS)) begin
        st_nxt.flags_seen = 1'b1;
      end
    end

    // Two-step clears; hardware sets below take priority
    if (wr_data && st_r.flags_seen) begin
      st_nxt.tx_buf_empty = 1'b0;
      st_nxt.tx_done      = 1'b0;
      st_nxt.flags_seen   = 1'b0;
    end
    if (rd_data && st_r.flags_seen) begin
      st_nxt.rx_buf_full = 1'b0;
      st_nxt.idle        = 1'b0;
      st_nxt.rx_ovfl     = 1'b0;
      st_nxt.flags_seen  = 1'b0;
    end

    // Transmitter control
    if (st_nxt.ctl.tx_on) begin
      st_nxt.tx_ever = 1'b1;
    end
    if (!st_nxt.ctl.tx_on && tx_busy) begin
      st_nxt.tx_off_busy = 1'b1;
    end
    if (tx_restart) begin
      st_nxt.tx_wait = 1'b1;
      if (st_r.tx_off_busy || tx_busy) begin
        st_nxt.pre_pend = 1'b1;
      end
      st_nxt.tx_off_busy = 1'b0;
    end else if (tx_tick) begin
      st_nxt.tx_wait = 1'b0;
    end
    if (!tx_busy) begin
      st_nxt.tx_off_busy = 1'b0;
    end
    if (st_r.ctl.tx_brk_send && !st_nxt.ctl.tx_brk_send) begin
      st_nxt.brk_pend = 1'b1;
    end
    if (tx_taken) begin
      case (tx_kind)
        ucbg_pkg::KIND_BREAK:    st_nxt.brk_pend = 1'b0;
        ucbg_pkg::KIND_PREAMBLE: st_nxt.pre_pend = 1'b0;
        default:                 st_nxt.tx_buf_empty = 1'b1;
      endcase
    end
    if (tx_frame_done && !tx_start) begin
      st_nxt.tx_done = 1'b1;
    end

    // Receiver
    st_nxt.rx_prev = rxd_in;
    if (!st_r.ctl.rx_on) begin
      st_nxt.rx_state  = ucbg_pkg::RX_IDLE;
      st_nxt.quiet_cnt = 4'h0;
    end else begin
      case (st_r.rx_state)
        ucbg_pkg::RX_IDLE: begin
          if (rx_restart) begin
            st_nxt.rx_state  = ucbg_pkg::RX_START;
            st_nxt.quiet_cnt = 4'h0;
          end else if (rx_tick && rxd_in && st_r.quiet_cnt != ucbg_pkg::IDLE_BITS) begin
            st_nxt.quiet_cnt = st_r.quiet_cnt + 4'h1;
          end
        end
        ucbg_pkg::RX_START: begin
          if (rx_tick) begin
            st_nxt.rx_state = rxd_in ? ucbg_pkg::RX_IDLE : ucbg_pkg::RX_DATA;
            st_nxt.rx_cnt   = 4'h0;
          end
        end
        ucbg_pkg::RX_DATA: begin
          if (rx_tick) begin
            st_nxt.rx_shift = {rxd_in, st_r.rx_shift[7:1]};
            st_nxt.rx_cnt   = st_r.rx_cnt + 4'h1;
            if (st_r.rx_cnt == ucbg_pkg::DATA_BITS - 4'h1) begin
              st_nxt.rx_state = ucbg_pkg::RX_STOP;
            end
          end
        end
        ucbg_pkg::RX_STOP: begin
          if (rx_tick) begin
            st_nxt.rx_state    = ucbg_pkg::RX_IDLE;
            st_nxt.quiet_armed = 1'b1;
            if (!st_r.ctl.rx_mute) begin
              if (st_r.rx_buf_full) begin
                st_nxt.rx_ovfl = 1'b1;
              end else begin
                st_nxt.rx_hold_buf = st_r.rx_shift;
                st_nxt.rx_buf_full = 1'b1;
              end
            end
          end
        end
        default: st_nxt.rx_state = ucbg_pkg::RX_IDLE;
      endcase
    end
    // Idle line: a full quiet frame after traffic
    if (st_r.quiet_armed && st_r.quiet_cnt == ucbg_pkg::IDLE_BITS) begin
      st_nxt.quiet_armed = 1'b0;
      if (st_r.ctl.rx_mute) begin
        st_nxt.ctl.rx_mute = 1'b0;
      end else begin
        st_nxt.idle = 1'b1;
      end
    end

    // Pin and interrupt outputs
    st_nxt.txd_oe = st_nxt.tx_ever & (st_nxt.ctl.tx_on | st_nxt.ctl.rx_on);
    st_nxt.txd    = st_r.ctl.tx_on ? tx_line : 1'b1;
    st_nxt.irq    = (st_r.ctl.tx_empty_irq_en & st_r.tx_buf_empty)
                  | (st_r.ctl.tx_done_irq_en & st_r.tx_done)
                  | (st_r.ctl.rx_full_irq_en & (st_r.rx_ovfl | st_r.rx_buf_full))
                  | (st_r.ctl.line_quiet_irq_en & st_r.idle);
  end

  ////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r              <= '0;
      st_r.ctl          <= ucbg_pkg::CTL_RESET;
      st_r.baud         <= ucbg_pkg::BAUD_RESET;
      st_r.rx_ext_div   <= ucbg_pkg::EXT_RESET;
      st_r.tx_ext_div   <= ucbg_pkg::EXT_RESET;
      st_r.tx_hold_buf  <= ucbg_pkg::HOLD_RESET;
      st_r.rx_hold_buf  <= ucbg_pkg::HOLD_RESET;
      st_r.tx_buf_empty <= ucbg_pkg::TX_EMPTY_RESET;
      st_r.tx_done      <= ucbg_pkg::TX_DONE_RESET;
      st_r.rx_state     <= ucbg_pkg::RX_IDLE;
      st_r.rx_prev      <= 1'b1;
      st_r.txd          <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_out  = st_r.prdata;
  assign pready_out  = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign txd_out     = st_r.txd;
  assign txd_oe_out  = st_r.txd_oe;
  assign irq_out     = st_r.irq;

endmodule : ucbg_top

// [hw/ucbg_tx_shift.sv]
// Output shifter for data, break and preamble frames
module ucbg_tx_shift (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  // Request
  input  wire logic                   tick_in,
  input  wire logic                   start_in,
  input  wire ucbg_pkg::ucbg_kind_type kind_in,
  input  wire logic [7:0]             data_in,
  // Status and line
  output logic                        line_out,
  output logic                        busy_out,
  output logic                        taken_out,
  output logic                        done_out
);

  typedef struct packed {
    logic [8:0] sh;
    logic [3:0] cnt;
    logic       busy;
    logic       line;
    logic       taken;
    logic       done;
    logic       is_data;
  } ucbg_tx_state_type;

  ucbg_tx_state_type st_r, st_nxt;
  logic [9:0]        frame;

  always_comb begin
    case (kind_in)
      ucbg_pkg::KIND_DATA:  frame = {1'b1, data_in, 1'b0};
      ucbg_pkg::KIND_BREAK: frame = 10'h000;
      default:              frame = 10'h3ff;
    endcase
    st_nxt       = st_r;
    st_nxt.taken = 1'b0;
    st_nxt.done  = 1'b0;
    if (tick_in) begin
      if (st_r.busy && st_r.cnt != 4'h0) begin
        st_nxt.line = st_r.sh[0];
        st_nxt.sh   = {1'b1, st_r.sh[8:1]};
        st_nxt.cnt  = st_r.cnt - 4'h1;
      end else begin
        // Stop bit done; next frame may follow
        st_nxt.done = st_r.busy & st_r.is_data;
        st_nxt.busy = 1'b0;
        st_nxt.line = 1'b1;
        if (start_in) begin
          st_nxt.line    = frame[0];
          st_nxt.sh      = frame[9:1];
          st_nxt.cnt     = ucbg_pkg::FRAME_LAST;
          st_nxt.busy    = 1'b1;
          st_nxt.taken   = 1'b1;
          st_nxt.is_data = (kind_in == ucbg_pkg::KIND_DATA);
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r      <= '0;
      st_r.line <= 1'b1;
      st_r.sh   <= 9'h1ff;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign line_out  = st_r.line;
  assign busy_out  = st_r.busy;
  assign taken_out = st_r.taken;
  assign done_out  = st_r.done;

endmodule : ucbg_tx_shift

// [verif/uart_ctl_baud_gen_bench.sv]
// Self-checking bench for the serial control and rate block
module uart_ctl_baud_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, rxd_in, txd_out, txd_oe_out, irq_out, line_w;
  logic [7:0]  rx_byte, v, rq;
  logic        rx_stop, rx_got;
  logic [15:0] bit_cyc = 16'h0060;
  logic [7:0]  exp_q[$], msk_q[$], tx_q[$];
  logic [7:0]  ra[5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [7:0]  ca[3] = '{8'h08, 8'h10, 8'h14};
  int          err_count = 0, compares = 0, seed = 96, brk = 0;
  always #5 clk_in = ~clk_in;
  // Released pin is pulled up
  assign line_w = txd_oe_out ? txd_out : 1'b1;
  ucbg_top i_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rxd_in, .txd_out, .txd_oe_out,
    .irq_out);
  ucbg_remote i_remote (.clk_in, .bit_in(bit_cyc), .txd_in(line_w), .rxd_out(rxd_in),
    .byte_out(rx_byte), .stop_out(rx_stop), .got_out(rx_got));
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic hang(input string m);
    chk(1'b0, m);
    report_and_stop();
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    int n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    q = prdata_out[7:0];
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) hang("bus");
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, e, m, output logic [7:0] q);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic poll(input logic [7:0] a, input int b, input logic l);
    int n = 0;
    do begin
      rd(a, 8'h00, 8'h00, rq);
      n++;
    end while (rq[b] !== l && n < 600);
    if (n >= 600) hang("poll");
  endtask : poll
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(irq_out === e, "irq");
    @(posedge clk_in);
  endtask : irq_is
  task automatic send_tx;
    v = 8'($random(seed));
    tx_q.push_back(v);
    rd(8'h00, 8'h80, 8'h80, rq);
    wr(8'h04, v);
    poll(8'h00, 6, 1'b1);
  endtask : send_tx
  task automatic send_rx;
    v = 8'($random(seed));
    i_remote.send(v);
    poll(8'h00, 5, 1'b1);
    rd(8'h04, v, 8'hff, rq);
  endtask : send_rx
  ////////////////////////////////////////
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      chk(exp_q.size() > 0 && ((prdata_out[7:0] ^ exp_q[0]) & msk_q[0]) == 8'h00, "read");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (rx_got === 1'b1) begin
      if (rx_stop === 1'b0) brk++;
      else chk(tx_q.size() > 0 && rx_byte === tx_q.pop_front(), "frame");
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    foreach (ra[i]) rd(ra[i], i ? 8'h00 : 8'hc0, i ? 8'hff : 8'hf8, rq);
    rd(8'h18, 8'h00, 8'hff, rq);
    wr(8'h0c, 8'h80);
    irq_is(1'b1);
    wr(8'h0c, 8'h40);
    irq_is(1'b1);
    wr(8'h0c, 8'h00);
    irq_is(1'b0);
    foreach (ca[i]) begin
      v = 8'($random(seed));
      wr(ca[i], v);
      rd(ca[i], v, 8'hff, rq);
    end
    wr(8'h08, 8'h49);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h0c, 8'h0c);
    send_tx();
    send_rx();
    i_remote.send(8'h5a);
    i_remote.send(8'ha5);
    wr(8'h0c, 8'h2c);
    irq_is(1'b1);
    rd(8'h00, 8'h28, 8'h28, rq);
    rd(8'h04, 8'h5a, 8'hff, rq);
    irq_is(1'b0);
    wr(8'h10, 8'h02);
    wr(8'h14, 8'h02);
    bit_cyc = 16'h0020;
    send_tx();
    send_rx();
    wr(8'h0c, 8'h0e);
    i_remote.send(v);
    poll(8'h0c, 1, 1'b0);
    rd(8'h00, 8'h00, 8'h20, rq);
    wr(8'h0c, 8'h0d);
    wr(8'h0c, 8'h0c);
    for (int n = 0; brk == 0; n++) begin
      if (n > 2000) hang("break");
      @(posedge clk_in);
    end
    chk(tx_q.size() == 0, "frames");
    report_and_stop();
  end
endmodule : uart_ctl_baud_gen_bench

// [verif/ucbg_monitor.sv]
// Port checker for the serial control and rate block
module ucbg_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              reset_n_in,
  // Bus and line
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              txd_out,
  input wire logic              txd_oe_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic       dn_w;
  logic [7:0] ctl_r, baud_r, txe_r;
  logic       ever_r, wdat_r;
  assign dn_w = psel_in && penable_in && pready_out;
  // Shadow of what software wrote
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_r  <= 8'h00;
      baud_r <= 8'h00;
      txe_r  <= 8'h00;
      ever_r <= 1'b0;
      wdat_r <= 1'b0;
    end else if (dn_w && pwrite_in) begin
      if (paddr_in == 8'h0c) {ever_r, ctl_r} <= {ever_r | pwdata_in[3], pwdata_in[7:0]};
      if (paddr_in == 8'h08) baud_r <= pwdata_in[7:0];
      if (paddr_in == 8'h14) txe_r <= pwdata_in[7:0];
      if (paddr_in == 8'h04) wdat_r <= 1'b1;
    end
  end
  ////////////////////////////////////////
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_quiet;
    txd_out [*8];
  endsequence
  property p_wait;
    s_setup ##1 psel_in && penable_in |-> !pready_out ##1 pready_out;
  endproperty
  property p_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_err;
    pready_out |-> pslverr_out == !(paddr_in[1:0] == 2'h0 && paddr_in <= 8'h14);
  endproperty
  property p_high;
    pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h000000;
  endproperty
  property p_baud;
    dn_w && !pwrite_in && paddr_in == 8'h08 |-> prdata_out[7:0] == baud_r;
  endproperty
  property p_txe;
    dn_w && !pwrite_in && paddr_in == 8'h14 |-> prdata_out[7:0] == txe_r;
  endproperty
  property p_oe;
    !ever_r |-> !txd_oe_out && txd_out;
  endproperty
  property p_delay;
    $rose(ever_r) |-> s_quiet;
  endproperty
  property p_irq_off;
    ctl_r[7:4] == 4'h0 && $past(ctl_r[7:4]) == 4'h0 |-> !irq_out;
  endproperty
  property p_irq_on;
    $rose(ctl_r[7]) && !wdat_r |-> ##[1:2] irq_out;
  endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_high: assert property (p_high) else $error("upper read bits set");
  a_baud: assert property (p_baud) else $error("rate readback");
  a_txe: assert property (p_txe) else $error("ext readback");
  a_oe: assert property (p_oe) else $error("pin taken early");
  a_delay: assert property (p_delay) else $error("no bit delay");
  a_irq_off: assert property (p_irq_off) else $error("irq leak");
  a_irq_on: assert property (p_irq_on) else $error("no empty irq");
endmodule : ucbg_monitor

bind ucbg_top ucbg_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk_in, .reset_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .txd_out, .txd_oe_out, .irq_out);

// [verif/ucbg_remote.sv]
// Far-end serial transceiver model
module ucbg_remote (
  // Clock and rate
  input  wire logic        clk_in,
  input  wire logic [15:0] bit_in,
  // Line
  input  wire logic        txd_in,
  output logic             rxd_out,
  // Received frame
  output logic [7:0]       byte_out,
  output logic             stop_out,
  output logic             got_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_out = 1'b1;
  initial got_out = 1'b0;
  // Sample each bit at its middle
  always @(negedge txd_in) begin
    repeat (bit_in / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_in) @(posedge clk_in);
      byte_out[i] <= txd_in;
    end
    repeat (bit_in) @(posedge clk_in);
    stop_out <= txd_in;
    got_out <= 1'b1;
    @(posedge clk_in);
    got_out <= 1'b0;
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (bit_in) @(posedge clk_in);
    end
  endtask : send
endmodule : ucbg_remote
